// file: hdl/mstc_pkg.sv
// Constants, field layout and decode tables for the motor start-up configuration word.
// Assumes one clock domain; decode tables are pure functions shared by the register bank.
package mstc_pkg;

   // Register map and reset value
   localparam logic [7:0]  MSTC_OFS_START_CFG = 8'h84;
   localparam logic [31:0] MSTC_START_CFG_RST = 32'h0000_0000;

   // Field positions (low bit of each field)
   localparam int MSTC_RSVD_POS   = 31;
   localparam int MSTC_METHOD_POS = 29;
   localparam int MSTC_RAMP_POS   = 25;
   localparam int MSTC_ALIGN_POS  = 21;
   localparam int MSTC_CAP_POS    = 17;
   localparam int MSTC_RATE_POS   = 14;
   localparam int MSTC_TRIP_POS   = 9;
   localparam int MSTC_REL_POS    = 8;
   localparam int MSTC_LEAD_POS   = 6;
   localparam int MSTC_COUNT_POS  = 4;
   localparam int MSTC_OLCAP_POS  = 3;
   localparam int MSTC_TQRAMP_POS = 2;
   localparam int MSTC_BRAKE_POS  = 1;
   localparam int MSTC_REVDRV_POS = 0;

   // Largest usable probe trip code; codes above it are not applicable
   localparam logic [4:0] MSTC_TRIP_MAX_CODE  = 5'h11;
   localparam logic [3:0] MSTC_RAMP_FREE_CODE = 4'hF;
   localparam logic [6:0] MSTC_LEAD_STEP_DEG  = 7'h1E;

   // Start-up method, in code order
   typedef enum logic [1:0] {
      MSTC_ALIGN,
      MSTC_DOUBLE_ALIGN,
      MSTC_POSITION_PROBE,
      MSTC_SLOW_FIRST_CYCLE
   } mstc_method_type;

   // Decoded configuration handed to the motor-control engine
   typedef struct packed {
      mstc_method_type start_method_select;
      logic [15:0]     ramp_rate_dapps;             // Ramp rate in 0.1 A/s
      logic            ramp_unlimited;
      logic [15:0]     align_time_ms;
      logic [15:0]     start_phase_current_cap_ma;
      logic [15:0]     position_probe_pulse_rate_hz;
      logic [15:0]     position_probe_current_trip_ma;
      logic            position_probe_trip_valid;
      logic            position_probe_release_style; // 0 brake, 1 high impedance
      logic [6:0]      position_probe_angle_lead_deg;
      logic [2:0]      position_probe_run_count;
      logic            open_loop_cap_source;
      logic            torque_current_ramp_on;
      logic            active_brake_on;
      logic            reverse_drive_option;
   } mstc_cfg_type;

   // Ramp rate in 0.1 A/s; the free-running code reads as zero
   function automatic logic [15:0] mstc_ramp_lut(input logic [3:0] code);
      logic [15:0] v;
      v = 16'h0000;
      unique case (code)
         4'h0: v = 16'h0001;
         4'h1: v = 16'h000A;
         4'h2: v = 16'h0032;
         4'h3: v = 16'h0064;
         4'h4: v = 16'h0096;
         4'h5: v = 16'h00FA;
         4'h6: v = 16'h01F4;
         4'h7: v = 16'h03E8;
         4'h8: v = 16'h05DC;
         4'h9: v = 16'h07D0;
         4'hA: v = 16'h09C4;
         4'hB: v = 16'h1388;
         4'hC: v = 16'h2710;
         4'hD: v = 16'h4E20;
         4'hE: v = 16'hC350;
         4'hF: v = 16'h0000;
      endcase
      return v;
   endfunction : mstc_ramp_lut

   // Align dwell in ms
   function automatic logic [15:0] mstc_align_lut(input logic [3:0] code);
      logic [15:0] v;
      v = 16'h0000;
      unique case (code)
         4'h0: v = 16'h000A;
         4'h1: v = 16'h0032;
         4'h2: v = 16'h0064;
         4'h3: v = 16'h00C8;
         4'h4: v = 16'h012C;
         4'h5: v = 16'h0190;
         4'h6: v = 16'h01F4;
         4'h7: v = 16'h02EE;
         4'h8: v = 16'h03E8;
         4'h9: v = 16'h05DC;
         4'hA: v = 16'h07D0;
         4'hB: v = 16'h0BB8;
         4'hC: v = 16'h0FA0;
         4'hD: v = 16'h1388;
         4'hE: v = 16'h1D4C;
         4'hF: v = 16'h2710;
      endcase
      return v;
   endfunction : mstc_align_lut

   // Align or slow first cycle current cap in mA
   function automatic logic [15:0] mstc_cap_lut(input logic [3:0] code);
      logic [15:0] v;
      v = 16'h0000;
      unique case (code)
         4'h0: v = 16'h007D;
         4'h1: v = 16'h00FA;
         4'h2: v = 16'h01F4;
         4'h3: v = 16'h03E8;
         4'h4: v = 16'h05DC;
         4'h5: v = 16'h07D0;
         4'h6: v = 16'h09C4;
         4'h7: v = 16'h0BB8;
         4'h8: v = 16'h0DAC;
         4'h9: v = 16'h0FA0;
         4'hA: v = 16'h1194;
         4'hB: v = 16'h1388;
         4'hC: v = 16'h157C;
         4'hD: v = 16'h1770;
         4'hE: v = 16'h1B58;
         4'hF: v = 16'h1F40;
      endcase
      return v;
   endfunction : mstc_cap_lut

   // Probe pulse rate in Hz
   function automatic logic [15:0] mstc_rate_lut(input logic [2:0] code);
      logic [15:0] v;
      v = 16'h0000;
      unique case (code)
         3'h0: v = 16'h0032;
         3'h1: v = 16'h0064;
         3'h2: v = 16'h00FA;
         3'h3: v = 16'h01F4;
         3'h4: v = 16'h03E8;
         3'h5: v = 16'h07D0;
         3'h6: v = 16'h1388;
         3'h7: v = 16'h2710;
      endcase
      return v;
   endfunction : mstc_rate_lut

   // Probe current trip in mA; not-applicable codes read as zero
   function automatic logic [15:0] mstc_trip_lut(input logic [4:0] code);
      logic [15:0] v;
      v = 16'h0000;
      case (code)
         5'h00: v = 16'h00FA;
         5'h01: v = 16'h01F4;
         5'h02: v = 16'h02EE;
         5'h03: v = 16'h03E8;
         5'h04: v = 16'h04E2;
         5'h05: v = 16'h05DC;
         5'h06: v = 16'h07D0;
         5'h07: v = 16'h09C4;
         5'h08: v = 16'h0BB8;
         5'h09: v = 16'h0E53;
         5'h0A: v = 16'h0FA0;
         5'h0B: v = 16'h123B;
         5'h0C: v = 16'h1388;
         5'h0D: v = 16'h14D5;
         5'h0E: v = 16'h1770;
         5'h0F: v = 16'h1A0B;
         5'h10: v = 16'h1CA5;
         5'h11: v = 16'h1F40;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : mstc_trip_lut

endpackage : mstc_pkg

// file: hdl/mstc_start_cfg.sv
// Motor start-up configuration word: storage, read-back and decode for the start-up engine.
// Assumes a simple synchronous register port from the device's register interface;
// one clock, asynchronous active-low reset.
// Decoded outputs change on the same edge as the stored word.
`timescale 1ns/1ps

module mstc_start_cfg
   import mstc_pkg::*;
#(
   parameter int ADDR_W = 8                         // Register address width
)(
   input  wire logic              clk,              // 100 MHz clock
   input  wire logic              rst_n,            // Asynchronous reset, active low
   input  wire logic              reg_wr,           // Write strobe, one cycle
   input  wire logic              reg_rd,           // Read strobe, one cycle
   input  wire logic [ADDR_W-1:0] reg_addr,         // Byte address
   input  wire logic [31:0]       reg_wdata,        // Write data
   output logic      [31:0]       reg_rdata,        // Read data, valid with reg_rvalid
   output logic                   reg_rvalid,       // Read answer pulse
   output logic      [31:0]       start_cfg_word,   // Raw stored word
   output mstc_cfg_type           start_cfg         // Decoded values for the engine
);

   logic [31:0]  word_r, word_nxt;
   logic [31:0]  rdata_r, rdata_nxt;
   logic         rvalid_r, rvalid_nxt;
   mstc_cfg_type cfg_r, cfg_nxt;
   logic         hit;

   // Full address compare: only the one word answers, no aliases at other offsets
   assign hit = (reg_addr == ADDR_W'(MSTC_OFS_START_CFG));

   // Next word, read answer and decode; decode follows word_nxt so outputs never lag the word
   always_comb
   begin
      word_nxt   = word_r;
      rdata_nxt  = 32'h0000_0000;
      rvalid_nxt = reg_rd;
      if (reg_wr && hit)
      begin
         word_nxt = reg_wdata;
      end
      if (reg_rd && hit)
      begin
         rdata_nxt = word_r;
      end
      // Unmapped reads answer zero so software never sees stale data
      cfg_nxt.start_method_select =
         mstc_method_type'(word_nxt[MSTC_METHOD_POS +: 2]);
      cfg_nxt.ramp_rate_dapps  = mstc_ramp_lut(word_nxt[MSTC_RAMP_POS +: 4]);
      cfg_nxt.ramp_unlimited   = (word_nxt[MSTC_RAMP_POS +: 4] == MSTC_RAMP_FREE_CODE);
      cfg_nxt.align_time_ms    = mstc_align_lut(word_nxt[MSTC_ALIGN_POS +: 4]);
      cfg_nxt.start_phase_current_cap_ma =
         mstc_cap_lut(word_nxt[MSTC_CAP_POS +: 4]);
      cfg_nxt.position_probe_pulse_rate_hz =
         mstc_rate_lut(word_nxt[MSTC_RATE_POS +: 3]);
      cfg_nxt.position_probe_current_trip_ma =
         mstc_trip_lut(word_nxt[MSTC_TRIP_POS +: 5]);
      // The engine must not probe against a zero trip; it checks this flag
      cfg_nxt.position_probe_trip_valid =
         (word_nxt[MSTC_TRIP_POS +: 5] <= MSTC_TRIP_MAX_CODE);
      cfg_nxt.position_probe_release_style = word_nxt[MSTC_REL_POS];
      cfg_nxt.position_probe_angle_lead_deg =
         7'(MSTC_LEAD_STEP_DEG * {5'h00, word_nxt[MSTC_LEAD_POS +: 2]});
      cfg_nxt.position_probe_run_count =
         3'({1'b0, word_nxt[MSTC_COUNT_POS +: 2]} + 3'h1);
      cfg_nxt.open_loop_cap_source   = word_nxt[MSTC_OLCAP_POS];
      cfg_nxt.torque_current_ramp_on = word_nxt[MSTC_TQRAMP_POS];
      cfg_nxt.active_brake_on        = word_nxt[MSTC_BRAKE_POS];
      cfg_nxt.reverse_drive_option   = word_nxt[MSTC_REVDRV_POS];
   end

   // State registers; reset values decode the all-zero word
   // Read data and its valid are registered, so the port answers one cycle after the strobe;
   // rdata is cleared between answers so a stray capture cannot pick up the stored word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_r   <= MSTC_START_CFG_RST;
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
         cfg_r    <= '{start_method_select: MSTC_ALIGN,
                       ramp_rate_dapps: 16'h0001,
                       align_time_ms: 16'h000A,
                       start_phase_current_cap_ma: 16'h007D,
                       position_probe_pulse_rate_hz: 16'h0032,
                       position_probe_current_trip_ma: 16'h00FA,
                       position_probe_trip_valid: 1'b1,
                       position_probe_run_count: 3'h1,
                       default: '0};
      end
      else
      begin
         word_r   <= word_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         cfg_r    <= cfg_nxt;
      end
   end

   assign reg_rdata      = rdata_r;
   assign reg_rvalid     = rvalid_r;
   assign start_cfg_word = word_r;
   assign start_cfg      = cfg_r;

   // Checks
   // Decode checks pin the end codes; the bench sweeps every code of every field
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_write_store;
      reg_wr && hit |=> (word_r == $past(reg_wdata));
   endproperty
   a_write_store: assert property (p_write_store) else $error("write not stored");

   property p_read_back;
      reg_rd && hit |=> reg_rvalid && reg_rdata == $past(start_cfg_word);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read-back mismatch");

   property p_unmapped;
      reg_rd && !hit |=> reg_rvalid && reg_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // Between answers the read port rests at zero
   property p_rdata_idle;
      !reg_rd |=> !reg_rvalid && reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read port not idle");

   // Only a write to the word's own offset may move it
   property p_word_hold;
      !(reg_wr && hit) |=> $stable(start_cfg_word);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed without write");

   property p_method;
      reg_wr && hit |=>
         start_cfg.start_method_select == mstc_method_type'($past(reg_wdata[30:29]));
   endproperty
   a_method: assert property (p_method) else $error("method decode wrong");

   property p_ramp_free;
      start_cfg.ramp_unlimited == (start_cfg_word[28:25] == 4'hF) &&
      (start_cfg.ramp_unlimited || start_cfg.ramp_rate_dapps != 16'h0000);
   endproperty
   a_ramp_free: assert property (p_ramp_free) else $error("ramp limit flag wrong");

   property p_ramp_ends;
      (start_cfg_word[28:25] == 4'h0 |-> start_cfg.ramp_rate_dapps == 16'h0001) and
      (start_cfg_word[28:25] == 4'hE |-> start_cfg.ramp_rate_dapps == 16'hC350);
   endproperty
   a_ramp_ends: assert property (p_ramp_ends) else $error("ramp rate wrong");

   property p_align_ends;
      (start_cfg_word[24:21] == 4'h0 |-> start_cfg.align_time_ms == 16'h000A) and
      (start_cfg_word[24:21] == 4'hF |-> start_cfg.align_time_ms == 16'h2710);
   endproperty
   a_align_ends: assert property (p_align_ends) else $error("align dwell wrong");

   property p_cap_ends;
      (start_cfg_word[20:17] == 4'h0 |-> start_cfg.start_phase_current_cap_ma == 16'h007D) and
      (start_cfg_word[20:17] == 4'hF |-> start_cfg.start_phase_current_cap_ma == 16'h1F40);
   endproperty
   a_cap_ends: assert property (p_cap_ends) else $error("current cap wrong");

   property p_rate_top;
      (start_cfg_word[16:14] == 3'h0 |-> start_cfg.position_probe_pulse_rate_hz == 16'h0032) and
      (start_cfg_word[16:14] == 3'h7 |-> start_cfg.position_probe_pulse_rate_hz == 16'h2710);
   endproperty
   a_rate_top: assert property (p_rate_top) else $error("probe rate wrong");

   property p_trip_valid;
      start_cfg.position_probe_trip_valid == (start_cfg_word[13:9] <= 5'h11) &&
      (start_cfg.position_probe_trip_valid ==
       (start_cfg.position_probe_current_trip_ma != 16'h0000));
   endproperty
   a_trip_valid: assert property (p_trip_valid) else $error("probe trip wrong");

   property p_trip_ends;
      (start_cfg_word[13:9] == 5'h00 |-> start_cfg.position_probe_current_trip_ma == 16'h00FA) and
      (start_cfg_word[13:9] == 5'h11 |-> start_cfg.position_probe_current_trip_ma == 16'h1F40);
   endproperty
   a_trip_ends: assert property (p_trip_ends) else $error("probe trip end wrong");

   property p_release_lead;
      start_cfg.position_probe_release_style == start_cfg_word[8] &&
      start_cfg.position_probe_angle_lead_deg == 7'(30 * start_cfg_word[7:6]);
   endproperty
   a_release_lead: assert property (p_release_lead) else $error("release or lead wrong");

   property p_run_count;
      start_cfg.position_probe_run_count == {1'b0, start_cfg_word[5:4]} + 3'h1;
   endproperty
   a_run_count: assert property (p_run_count) else $error("run count wrong");

   property p_options;
      {start_cfg.open_loop_cap_source, start_cfg.torque_current_ramp_on,
       start_cfg.active_brake_on, start_cfg.reverse_drive_option} == start_cfg_word[3:0] &&
      (!$changed(start_cfg_word[3:0]) || $past(reg_wr && hit));
   endproperty
   a_options: assert property (p_options) else $error("option bits wrong");

   // Scenarios a run should reach
   c_probe_mode: cover property (reg_wr && hit && reg_wdata[30:29] == 2'h2);
   c_read_hit:   cover property (reg_rd && hit ##1 reg_rvalid && reg_rdata != 32'h0000_0000);
   c_bad_trip:   cover property (!start_cfg.position_probe_trip_valid);
   c_free_ramp:  cover property (start_cfg.ramp_unlimited);
   c_unmap_rd:   cover property (reg_rd && !hit ##1 reg_rvalid);

endmodule : mstc_start_cfg

// file: dv/mstc_start_cfg_test.sv
// Self-checking bench for the motor start-up configuration word.
// Assumes the design's strobe port: one-cycle strobes, read answer one cycle later.
`timescale 1ns/1ps

module mstc_start_cfg_test;
   import mstc_pkg::*;

   logic         clk;
   logic         rst_n;
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_addr;
   logic [31:0]  reg_wdata;
   logic [31:0]  reg_rdata;
   logic         reg_rvalid;
   logic [31:0]  start_cfg_word;
   mstc_cfg_type start_cfg;
   int           err_total;
   int           checked;
   logic [31:0]  rd_val;
   logic [31:0]  w;

   // Expected decode tables, worked out by hand from the field codes
   logic [15:0] ramp_t [16] = '{16'h0001, 16'h000A, 16'h0032, 16'h0064, 16'h0096, 16'h00FA,
      16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4, 16'h1388, 16'h2710, 16'h4E20,
      16'hC350, 16'h0000};
   logic [15:0] align_t [16] = '{16'h000A, 16'h0032, 16'h0064, 16'h00C8, 16'h012C, 16'h0190,
      16'h01F4, 16'h02EE, 16'h03E8, 16'h05DC, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388,
      16'h1D4C, 16'h2710};
   logic [15:0] cap_t [16] = '{16'h007D, 16'h00FA, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0,
      16'h09C4, 16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h1194, 16'h1388, 16'h157C, 16'h1770,
      16'h1B58, 16'h1F40};
   logic [15:0] rate_t [8] = '{16'h0032, 16'h0064, 16'h00FA, 16'h01F4, 16'h03E8, 16'h07D0,
      16'h1388, 16'h2710};
   logic [15:0] trip_t [18] = '{16'h00FA, 16'h01F4, 16'h02EE, 16'h03E8, 16'h04E2, 16'h05DC,
      16'h07D0, 16'h09C4, 16'h0BB8, 16'h0E53, 16'h0FA0, 16'h123B, 16'h1388, 16'h14D5,
      16'h1770, 16'h1A0B, 16'h1CA5, 16'h1F40};

   mstc_start_cfg u_dut (
      .clk            (clk),
      .rst_n          (rst_n),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_rdata      (reg_rdata),
      .reg_rvalid     (reg_rvalid),
      .start_cfg_word (start_cfg_word),
      .start_cfg      (start_cfg)
   );

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_word

   task automatic chk_cfg(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_cfg

   // Write strobe for one cycle; returns just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask : wr

   // Read strobe; answer is looked at in its one valid cycle, then must drop
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      chk_word("rvalid", 32'h1, 32'(reg_rvalid));
      d = reg_rdata;
      @(posedge clk);
      #1 chk_word("rvalid_drop", 32'h0, 32'(reg_rvalid));
      chk_word("rdata_drop", 32'h0, reg_rdata);
   endtask : rd

   // Compare every decoded field against the stored word's codes
   task automatic chk_dec(input logic [31:0] x);
      chk_word("word", x, start_cfg_word);
      chk_cfg("method", 16'(x[30:29]), 16'(start_cfg.start_method_select));
      chk_cfg("ramp", ramp_t[x[28:25]], start_cfg.ramp_rate_dapps);
      chk_cfg("unlim", 16'(x[28:25] == 4'hF), 16'(start_cfg.ramp_unlimited));
      chk_cfg("align", align_t[x[24:21]], start_cfg.align_time_ms);
      chk_cfg("cap", cap_t[x[20:17]], start_cfg.start_phase_current_cap_ma);
      chk_cfg("rate", rate_t[x[16:14]], start_cfg.position_probe_pulse_rate_hz);
      chk_cfg("trip", (x[13:9] > 5'h11) ? 16'h0000 : trip_t[x[13:9]],
              start_cfg.position_probe_current_trip_ma);
      chk_cfg("trip_ok", 16'(x[13:9] <= 5'h11), 16'(start_cfg.position_probe_trip_valid));
      chk_cfg("release", 16'(x[8]), 16'(start_cfg.position_probe_release_style));
      chk_cfg("lead", 16'h001E * 16'(x[7:6]), 16'(start_cfg.position_probe_angle_lead_deg));
      chk_cfg("runs", 16'(x[5:4]) + 16'h0001, 16'(start_cfg.position_probe_run_count));
      chk_cfg("opts", 16'(x[3:0]), 16'({start_cfg.open_loop_cap_source,
              start_cfg.torque_current_ramp_on, start_cfg.active_brake_on,
              start_cfg.reverse_drive_option}));
   endtask : chk_dec

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #50000;
      err_total++;
      $display("BAD watchdog expected done seen hang");
      end_of_test();
   end

   // Main sequence
   initial
   begin
      err_total = 0;
      checked = 0;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      // Outputs must already sit at reset values while reset is held
      #1 chk_dec(32'h0000_0000);
      chk_word("rvalid_rst", 32'h0, 32'(reg_rvalid));
      rst_n = 1'b1;
      rd(8'h84, rd_val);
      chk_word("rd_reset", 32'h0000_0000, rd_val);
      $display("test reset done");

      // Sweep every code of every field, bit 31 included, write then read back to back
      for (int i = 0; i < 32; i++)
      begin
         w = {i[0], i[1:0], i[3:0], ~i[3:0], i[3:0], i[2:0], i[4:0], i[0], i[1:0], i[1:0],
              i[3:0]};
         wr(8'h84, w);
         chk_dec(w);
         rd(8'h84, rd_val);
         chk_word("rd_back", w, rd_val);
      end
      $display("test field sweep done");

      // Unmapped places: writes ignored, reads answer zero
      wr(8'h84, 32'hA5C3_3C5A);
      // Let an edge pass so the next write strobe is not lowered and raised in one step
      @(posedge clk);
      #1;
      foreach (ramp_t[k])
      begin
         if (k < 4)
         begin
            wr(8'h80 + 8'(k * 3), 32'hFFFF_FFFF);
            rd(8'h85 + 8'(k), rd_val);
            chk_word("rd_unmapped", 32'h0000_0000, rd_val);
         end
      end
      chk_dec(32'hA5C3_3C5A);
      $display("test unmapped done");

      // Read and write of the word in one cycle: read sees the old value
      reg_wr = 1'b1;
      reg_rd = 1'b1;
      reg_addr = 8'h84;
      reg_wdata = 32'h7FFF_FFFF;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      reg_rd = 1'b0;
      chk_word("rd_old", 32'hA5C3_3C5A, reg_rdata);
      chk_dec(32'h7FFF_FFFF);
      $display("test same cycle done");

      // Second reset in mid-run clears the word again
      rst_n = 1'b0;
      @(posedge clk);
      #1 chk_dec(32'h0000_0000);
      chk_word("rvalid_rst2", 32'h0, 32'(reg_rvalid));
      rst_n = 1'b1;
      rd(8'h84, rd_val);
      chk_word("rd_reset2", 32'h0000_0000, rd_val);
      $display("test second reset done");
      end_of_test();
   end

endmodule : mstc_start_cfg_test
